// ### core/piirq_pkg.sv
// constants and carrier types for the port pin interrupt inputs
package piirq_pkg;

    localparam int N_RISE = 7;
    localparam int N_FALL = 5;
    localparam int N_EDGE = 12;
    localparam int N_LVL  = 2;
    localparam int DW     = 16;
    localparam int AW     = 4;
    localparam int BCRW   = 8;

    // field positions
    localparam int RISE_LSB    = 0;
    localparam int FALL_LSB    = 7;
    localparam int IRQ_SEL_BIT = 6;

    // register offsets
    localparam logic [AW-1:0] OFF_BUS_CTRL  = 4'h0;
    localparam logic [AW-1:0] OFF_EDGE_SEL  = 4'h1;
    localparam logic [AW-1:0] OFF_EDGE_FLAG = 4'h2;
    localparam logic [AW-1:0] OFF_EDGE_CLR  = 4'h3;
    localparam logic [AW-1:0] OFF_EDGE_EN   = 4'h4;
    localparam logic [AW-1:0] OFF_LVL_FLAG  = 4'h5;
    localparam logic [AW-1:0] OFF_LVL_CLR   = 4'h6;
    localparam logic [AW-1:0] OFF_LVL_EN    = 4'h7;
    localparam logic [AW-1:0] OFF_PIN_STATE = 4'h8;

    // reset values
    localparam logic [BCRW-1:0]   RST_BUS_CTRL = 8'h00;
    localparam logic [N_EDGE-1:0] RST_EDGE_SEL = 12'h000;
    localparam logic [N_EDGE-1:0] RST_EDGE     = 12'h000;
    localparam logic [N_LVL-1:0]  RST_LVL      = 2'h0;
    localparam logic [DW-1:0]     RST_RDATA    = 16'h0000;

    typedef struct packed {
        logic [N_RISE-1:0] rising;
        logic [N_FALL-1:0] falling;
        logic [N_LVL-1:0]  level_n;
        logic              nmi_n;
    } piirq_pins_t;

    localparam piirq_pins_t RST_PINS = '{
        rising: 7'h00, falling: 5'h1F, level_n: 2'h3, nmi_n: 1'h1};

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } piirq_req_t;

endpackage

// ### core/piirq_top.sv
// port pin interrupt inputs: edge, level and non-maskable detection
module piirq_top
    import piirq_pkg::*;
(
    input  wire logic                   clk_i,          // system clock
    input  wire logic                   rst_i,          // async reset, high
    input  wire piirq_pkg::piirq_pins_t pins_i,         // interrupt pins
    input  wire logic                   irq_disable_i,  // processor mask flag
    input  wire piirq_pkg::piirq_req_t  req_i,          // register request
    output logic [piirq_pkg::DW-1:0]    rd_data_o,      // read data
    output logic                        irq_o,          // maskable request
    output logic                        nmi_o           // nmi pulse
);
    import piirq_pkg::*;

    function automatic logic hit(input piirq_req_t r, input logic [AW-1:0] off);
        hit = (r.addr == off);
    endfunction

    piirq_pins_t       smp_q;
    piirq_pins_t       prev_q;
    logic [BCRW-1:0]   bcr_q;
    logic [N_EDGE-1:0] edge_sel_q;
    logic [N_EDGE-1:0] edge_flag_q;
    logic [N_EDGE-1:0] edge_flag_d;
    logic [N_EDGE-1:0] edge_en_q;
    logic [N_LVL-1:0]  lvl_flag_q;
    logic [N_LVL-1:0]  lvl_flag_d;
    logic [N_LVL-1:0]  lvl_en_q;
    logic [N_EDGE-1:0] edge_ev;
    logic [N_EDGE-1:0] edge_set;
    logic [N_EDGE-1:0] edge_clr;
    logic [N_LVL-1:0]  lvl_set;
    logic [N_LVL-1:0]  lvl_clr;
    logic              lvl_sel;
    logic              nmi_fall;
    logic              irq_d;

    // pin sampling and previous sample
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_q  <= RST_PINS;
            prev_q <= RST_PINS;
        end else begin
            smp_q  <= pins_i;
            prev_q <= smp_q;
        end
    end

    assign lvl_sel = bcr_q[IRQ_SEL_BIT];

    // edge detection against the previous sample
    always_comb begin
        edge_ev = '0;
        edge_ev[RISE_LSB +: N_RISE] = smp_q.rising & ~prev_q.rising;
        edge_ev[FALL_LSB +: N_FALL] = ~smp_q.falling & prev_q.falling;
    end

    assign edge_set = edge_ev & edge_sel_q;
    assign lvl_set  = lvl_sel ? ~smp_q.level_n : '0;
    assign nmi_fall = lvl_sel & prev_q.nmi_n & ~smp_q.nmi_n;

    assign edge_clr = (req_i.wr && hit(req_i, OFF_EDGE_CLR))
                      ? req_i.wdata[N_EDGE-1:0] : '0;
    assign lvl_clr  = (req_i.wr && hit(req_i, OFF_LVL_CLR))
                      ? req_i.wdata[N_LVL-1:0] : '0;

    // set wins over a clear in the same cycle
    assign edge_flag_d = (edge_flag_q & ~edge_clr) | edge_set;
    assign lvl_flag_d  = (lvl_flag_q & ~lvl_clr) | lvl_set;

    // writable control registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bcr_q      <= RST_BUS_CTRL;
            edge_sel_q <= RST_EDGE_SEL;
            edge_en_q  <= RST_EDGE;
            lvl_en_q   <= RST_LVL;
        end else if (req_i.wr) begin
            if (hit(req_i, OFF_BUS_CTRL)) begin
                bcr_q <= req_i.wdata[BCRW-1:0];
            end else if (hit(req_i, OFF_EDGE_SEL)) begin
                edge_sel_q <= req_i.wdata[N_EDGE-1:0];
            end else if (hit(req_i, OFF_EDGE_EN)) begin
                edge_en_q <= req_i.wdata[N_EDGE-1:0];
            end else if (hit(req_i, OFF_LVL_EN)) begin
                lvl_en_q <= req_i.wdata[N_LVL-1:0];
            end
        end
    end

    // sticky status flags
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_flag_q <= RST_EDGE;
            lvl_flag_q  <= RST_LVL;
        end else begin
            edge_flag_q <= edge_flag_d;
            lvl_flag_q  <= lvl_flag_d;
        end
    end

    // maskable request gated by the processor disable flag
    assign irq_d = !irq_disable_i &&
                   ((|(edge_flag_q & edge_en_q)) ||
                    (|(lvl_flag_q & lvl_en_q)));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_d;
        end
    end

    // nmi: only the select bit gates it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_o <= 1'b0;
        end else begin
            nmi_o <= nmi_fall;
        end
    end

    // read port, data valid the cycle after the strobe only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= RST_RDATA;
        end else if (!req_i.rd) begin
            rd_data_o <= RST_RDATA;
        end else if (hit(req_i, OFF_BUS_CTRL)) begin
            rd_data_o <= {{(DW-BCRW){1'b0}}, bcr_q};
        end else if (hit(req_i, OFF_EDGE_SEL)) begin
            rd_data_o <= {{(DW-N_EDGE){1'b0}}, edge_sel_q};
        end else if (hit(req_i, OFF_EDGE_FLAG)) begin
            rd_data_o <= {{(DW-N_EDGE){1'b0}}, edge_flag_q};
        end else if (hit(req_i, OFF_EDGE_EN)) begin
            rd_data_o <= {{(DW-N_EDGE){1'b0}}, edge_en_q};
        end else if (hit(req_i, OFF_LVL_FLAG)) begin
            rd_data_o <= {{(DW-N_LVL){1'b0}}, lvl_flag_q};
        end else if (hit(req_i, OFF_LVL_EN)) begin
            rd_data_o <= {{(DW-N_LVL){1'b0}}, lvl_en_q};
        end else if (hit(req_i, OFF_PIN_STATE)) begin
            rd_data_o <= {1'b0, smp_q};
        end else begin
            rd_data_o <= RST_RDATA;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [N_LVL-1:0] lvl_act;
    assign lvl_act = lvl_sel ? (~smp_q.level_n & lvl_en_q) : '0;

    // raw pin edges, independent of the flag update path
    logic [N_RISE-1:0] rise_seen;
    logic [N_FALL-1:0] fall_seen;
    logic              irq_src;
    assign rise_seen = smp_q.rising & ~prev_q.rising & edge_sel_q[RISE_LSB +: N_RISE];
    assign fall_seen = prev_q.falling & ~smp_q.falling & edge_sel_q[FALL_LSB +: N_FALL];
    assign irq_src   = |{edge_flag_q & edge_en_q, lvl_flag_q & lvl_en_q};

    property p_rise_sets;
        (edge_set[RISE_LSB +: N_RISE] != '0) |=>
            ((edge_flag_q[RISE_LSB +: N_RISE] & $past(edge_set[RISE_LSB +: N_RISE]))
             == $past(edge_set[RISE_LSB +: N_RISE]));
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rising edge did not set its flag");

    property p_fall_sets;
        (smp_q.falling != pins_i.falling) && (edge_sel_q[FALL_LSB +: N_FALL] != '0)
            ##1 (edge_set[FALL_LSB +: N_FALL] != '0) |=>
            ((edge_flag_q[FALL_LSB +: N_FALL] & $past(edge_set[FALL_LSB +: N_FALL]))
             == $past(edge_set[FALL_LSB +: N_FALL]));
    endproperty
    a_fall_sets: assert property (p_fall_sets)
        else $error("falling edge did not set its flag");

    property p_no_spurious_set;
        ((edge_flag_q & ~$past(edge_flag_q)) & ~$past(edge_set)) == '0;
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set)
        else $error("edge flag set without a selected edge");

    property p_mask_blocks;
        irq_disable_i |=> !irq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("maskable request while disabled");

    property p_edge_irq;
        ((edge_flag_q & edge_en_q) != '0) && !irq_disable_i |=> irq_o;
    endproperty
    a_edge_irq: assert property (p_edge_irq)
        else $error("enabled edge flag gave no request");

    property p_level_sets;
        lvl_sel && (smp_q.level_n != 2'h3) |=>
            ((lvl_flag_q & ~$past(smp_q.level_n)) == ~$past(smp_q.level_n));
    endproperty
    a_level_sets: assert property (p_level_sets)
        else $error("low level input did not set its flag");

    property p_level_holds;
        ((lvl_act != '0) && !irq_disable_i)[*3] |=> irq_o;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("held level request lost its interrupt");

    property p_level_irq;
        ((lvl_flag_q & lvl_en_q) != '0) && !irq_disable_i |=> irq_o;
    endproperty
    a_level_irq: assert property (p_level_irq)
        else $error("enabled level flag gave no request");

    property p_level_off;
        (lvl_flag_q == '0) && ((edge_flag_q & edge_en_q) == '0) |=> !irq_o;
    endproperty
    a_level_off: assert property (p_level_off)
        else $error("request without an enabled flag");

    property p_nmi_fires;
        lvl_sel && prev_q.nmi_n && !smp_q.nmi_n |=> nmi_o;
    endproperty
    a_nmi_fires: assert property (p_nmi_fires)
        else $error("nmi falling edge missed");

    property p_nmi_gate;
        nmi_o |-> $past(lvl_sel) && $past(prev_q.nmi_n) && !$past(smp_q.nmi_n);
    endproperty
    a_nmi_gate: assert property (p_nmi_gate)
        else $error("nmi without selected falling edge");

    property p_nmi_unmasked;
        irq_disable_i && nmi_fall |=> nmi_o;
    endproperty
    a_nmi_unmasked: assert property (p_nmi_unmasked)
        else $error("nmi blocked by the disable flag");

    property p_set_beats_clear;
        (edge_set & edge_clr) != '0 |=>
            ((edge_flag_q & $past(edge_set & edge_clr)) == $past(edge_set & edge_clr));
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("clear beat a simultaneous set");

    property p_rd_one_cycle;
        !req_i.rd |=> (rd_data_o == '0);
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle)
        else $error("read data outside its cycle");

    property p_rise_raw;
        (rise_seen != '0) |=>
            ((edge_flag_q[RISE_LSB +: N_RISE] & $past(rise_seen)) == $past(rise_seen));
    endproperty
    a_rise_raw: assert property (p_rise_raw)
        else $error("selected rising pin edge not flagged");

    property p_fall_raw;
        (fall_seen != '0) |=>
            ((edge_flag_q[FALL_LSB +: N_FALL] & $past(fall_seen)) == $past(fall_seen));
    endproperty
    a_fall_raw: assert property (p_fall_raw)
        else $error("selected falling pin edge not flagged");

    property p_rise_one_way;
        ((edge_flag_q[RISE_LSB +: N_RISE] & ~$past(edge_flag_q[RISE_LSB +: N_RISE]))
            & ~$past(rise_seen)) == '0;
    endproperty
    a_rise_one_way: assert property (p_rise_one_way)
        else $error("rising flag set without a rising edge");

    property p_fall_one_way;
        ((edge_flag_q[FALL_LSB +: N_FALL] & ~$past(edge_flag_q[FALL_LSB +: N_FALL]))
            & ~$past(fall_seen)) == '0;
    endproperty
    a_fall_one_way: assert property (p_fall_one_way)
        else $error("falling flag set without a falling edge");

    property p_irq_needs_unmask;
        irq_o |-> !$past(irq_disable_i) && $past(irq_src);
    endproperty
    a_irq_needs_unmask: assert property (p_irq_needs_unmask)
        else $error("request without an unmasked enabled flag");

    property p_level_needs_sel;
        !lvl_sel |=> ((lvl_flag_q & ~$past(lvl_flag_q)) == '0);
    endproperty
    a_level_needs_sel: assert property (p_level_needs_sel)
        else $error("level flag set while level inputs unselected");

    property p_nmi_quiet;
        !lvl_sel |=> !nmi_o;
    endproperty
    a_nmi_quiet: assert property (p_nmi_quiet)
        else $error("nmi while the nmi input is unselected");

    property p_edge_sticky;
        (($past(edge_flag_q & ~edge_clr) & ~edge_flag_q) == '0);
    endproperty
    a_edge_sticky: assert property (p_edge_sticky)
        else $error("edge flag dropped without a clear");

    property p_level_sticky;
        (($past(lvl_flag_q & ~lvl_clr) & ~lvl_flag_q) == '0);
    endproperty
    a_level_sticky: assert property (p_level_sticky)
        else $error("level flag dropped without a clear");

    property p_nmi_one_pulse;
        nmi_o |=> !nmi_o;
    endproperty
    a_nmi_one_pulse: assert property (p_nmi_one_pulse)
        else $error("nmi pulse longer than one cycle");

    property p_lvl_mask;
        irq_disable_i && ((lvl_flag_q & lvl_en_q) != '0) |=> !irq_o;
    endproperty
    a_lvl_mask: assert property (p_lvl_mask)
        else $error("level request passed the disable flag");

    property p_edge_clear;
        ((edge_clr & ~edge_set) != '0) |=>
            ((edge_flag_q & $past(edge_clr & ~edge_set)) == '0);
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("edge flag survived its clear");

    property p_rd_flag_data;
        req_i.rd && hit(req_i, OFF_EDGE_FLAG) |=>
            (rd_data_o == {{(DW-N_EDGE){1'b0}}, $past(edge_flag_q)});
    endproperty
    a_rd_flag_data: assert property (p_rd_flag_data)
        else $error("edge flag read returned wrong data");

    c_rise: cover property (edge_set[RISE_LSB +: N_RISE] != '0 ##1 irq_o);
    c_level: cover property ((lvl_act != '0)[*3] ##1 irq_o);
    c_nmi: cover property (irq_disable_i && nmi_fall ##1 nmi_o);
    c_collide: cover property ((edge_set & edge_clr) != '0);
    c_fall: cover property ((fall_seen != '0) ##1 (edge_flag_q != '0));

endmodule

// ### testbench/piirq_src_model.sv
// far side model: pin sources and nmi pulse counter
module piirq_src_model
    import piirq_pkg::*;
(
    input  wire logic                   clk_i,      // system clock
    input  wire logic                   rst_i,      // async reset, high
    input  wire piirq_pkg::piirq_pins_t want_i,     // requested pin levels
    input  wire logic                   nmi_i,      // nmi pulse from block
    output piirq_pkg::piirq_pins_t      pins_o,     // pins as driven
    output logic [7:0]                  nmi_cnt_o   // nmi pulses seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins change just after the edge, idle during reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) pins_o <= RST_PINS;
        else       pins_o <= want_i;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)      nmi_cnt_o <= 8'h00;
        else if (nmi_i) nmi_cnt_o <= nmi_cnt_o + 8'h01;
    end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the port pin interrupt inputs
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import piirq_pkg::*;
    logic          clk_i, rst_i, irq_disable_i, irq_o, nmi_o;
    piirq_req_t    req_i;
    piirq_pins_t   want, pins;
    logic [DW-1:0] rd_data_o, v, w;
    logic [7:0]    nmi_cnt;
    int            fails, check_count;

    piirq_top u_piirq_top (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
        .irq_disable_i(irq_disable_i), .req_i(req_i), .rd_data_o(rd_data_o),
        .irq_o(irq_o), .nmi_o(nmi_o));
    piirq_src_model u_piirq_src_model (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
        .nmi_i(nmi_o), .pins_o(pins), .nmi_cnt_o(nmi_cnt));

    function automatic piirq_pins_t drive_edge(piirq_pins_t p, int i, logic act);
        if (i < N_RISE) p.rising[i] = act;
        else            p.falling[i-N_RISE] = ~act;
        return p;
    endfunction
    function automatic logic [DW-1:0] bit_of(int i);
        return 16'h0001 << i;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_i);
        req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_i);
        req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_i);
        req_i.rd <= 1'b0;
        @(negedge clk_i);
        d = rd_data_o;
        @(posedge clk_i);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        fails++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        irq_disable_i = 1'b0;
        req_i = '0;
        want = RST_PINS;
        fails = 0;
        check_count = 0;
        void'($urandom(32'h5E3F));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped and read-only places
        for (int a = 0; a < 16; a++) begin
            rd(a[AW-1:0], v);
            chk(v, (a == OFF_PIN_STATE) ? {1'b0, RST_PINS} : 16'h0000);
        end
        wr(OFF_EDGE_FLAG, 16'hFFFF);
        rd(OFF_EDGE_FLAG, v);
        chk(v, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            w = 16'($urandom);
            wr(OFF_EDGE_EN, w);
            rd(OFF_EDGE_EN, v);
            chk(v, w & 16'h0FFF);
        end
        // unselected pin ignores edges
        wr(OFF_EDGE_EN, 16'h0FFF);
        want <= drive_edge(want, 0, 1'b1);
        idle(4);
        rd(OFF_EDGE_FLAG, v);
        chk(v, 16'h0000);
        want <= drive_edge(want, 0, 1'b0);
        wr(OFF_EDGE_SEL, 16'hFFFF);
        // every edge pin: set, mask, one-shot, opposite edge
        for (int i = 0; i < N_EDGE; i++) begin
            want <= drive_edge(want, i, 1'b1);
            idle(4);
            rd(OFF_EDGE_FLAG, v);
            chk(v, bit_of(i));
            chk({15'h0000, irq_o}, 16'h0001);
            irq_disable_i <= 1'b1;
            idle(2);
            chk({15'h0000, irq_o}, 16'h0000);
            irq_disable_i <= 1'b0;
            wr(OFF_EDGE_CLR, bit_of(i));
            idle(2);
            rd(OFF_EDGE_FLAG, v);
            chk(v, 16'h0000);
            want <= drive_edge(want, i, 1'b0);
            idle(4);
            rd(OFF_EDGE_FLAG, v);
            chk(v, 16'h0000);
        end
        // clear lands with the edge: set wins; enable gates the request
        want <= drive_edge(want, 0, 1'b1);
        idle(1);
        wr(OFF_EDGE_CLR, bit_of(0));
        rd(OFF_EDGE_FLAG, v);
        chk(v, bit_of(0));
        wr(OFF_EDGE_EN, 16'h0FFE);
        idle(2);
        chk({15'h0000, irq_o}, 16'h0000);
        wr(OFF_EDGE_EN, 16'h0FFF);
        idle(2);
        chk({15'h0000, irq_o}, 16'h0001);
        wr(OFF_EDGE_CLR, bit_of(0));
        want <= drive_edge(want, 0, 1'b0);
        idle(4);
        // level requests
        want.level_n <= 2'h0;
        idle(4);
        rd(OFF_LVL_FLAG, v);
        chk(v, 16'h0000);
        wr(OFF_BUS_CTRL, 16'hFF40);
        rd(OFF_BUS_CTRL, v);
        chk(v, 16'h0040);
        rd(OFF_LVL_FLAG, v);
        chk(v, 16'h0003);
        wr(OFF_LVL_CLR, 16'h0003);
        idle(1);
        rd(OFF_LVL_FLAG, v);
        chk(v, 16'h0003);
        wr(OFF_LVL_EN, 16'h0002);
        idle(2);
        chk({15'h0000, irq_o}, 16'h0001);
        irq_disable_i <= 1'b1;
        idle(2);
        chk({15'h0000, irq_o}, 16'h0000);
        // nmi ignores the mask flag
        want.nmi_n <= 1'b0;
        idle(5);
        chk({8'h00, nmi_cnt}, 16'h0001);
        want <= '{rising: want.rising, falling: want.falling, level_n: 2'h3, nmi_n: 1'b1};
        idle(4);
        chk({8'h00, nmi_cnt}, 16'h0001);
        wr(OFF_LVL_CLR, 16'h0003);
        idle(2);
        rd(OFF_LVL_FLAG, v);
        chk(v, 16'h0000);
        wr(OFF_BUS_CTRL, 16'h0000);
        want.nmi_n <= 1'b0;
        idle(5);
        chk({8'h00, nmi_cnt}, 16'h0001);
        rd(OFF_PIN_STATE, v);
        chk(v, {1'b0, want});
        // second reset mid-run
        rst_i <= 1'b1;
        idle(2);
        rst_i <= 1'b0;
        rd(OFF_EDGE_EN, v);
        chk(v, 16'h0000);
        end_of_test();
    end
endmodule
